// ==== hw/iopg_map.svh ====
/*
 Register indices, field positions, reset values and timing counts of the
 I/O pin port group. Assumes a 32-bit AHB-Lite bus, byte address = 4 * index.
*/
//
// Contract
// RULE_01 - After reset all drivers are off and all input buffers are on.
// RULE_02 - One group drives at most eight pins, one bit each in direction and level.
// RULE_03 - Direction bit 1 enables the pin driver with the drive level bit.
// RULE_04 - Pin level is synchronised before reaching the input register, either direction.
// RULE_05 - Direction-set alias sets written one bits, leaves zero bits alone.
// RULE_06 - Direction-clear alias clears written one bits, leaves others alone.
// RULE_07 - Direction-toggle alias inverts written one bits.
// RULE_08 - Drive-level set alias sets written one bits, zeros change nothing.
// RULE_09 - Drive-level clear alias clears written one bits, zeros change nothing.
// RULE_10 - Writing ones to the toggle alias or input register inverts drive level.
// RULE_11 - One slew limit bit applies slew limiting to all pins together.
// RULE_12 - Per-pin control register for pin n sits at sixteen plus n.
// RULE_13 - Polarity invert flips both input and output of that pin.
// RULE_14 - Changing polarity invert makes an edge seen by peripherals, interrupts and events.
// RULE_15 - Pull-up connects when enabled, but never while the pin is an output.
// RULE_16 - Buffer-off sense setting freezes the pin's input register bit.
// RULE_17 - Sense field enables the interrupt: both, rising, falling edge or low level.
// RULE_18 - Fast alias registers behave exactly as the registers they mirror.
// RULE_19 - Pin change sensing works without the clock and can wake the device.
// RULE_20 - Interrupt request holds while sense enabled and flag set, until cleared.
// RULE_21 - Event output follows the pin with buffer on, else zero.
// RULE_22 - No new interrupt for a pin within three clocks of the last.
// RULE_23 - Writing one to a flag bit clears it, zero leaves it.
// RULE_24 - Sense field encoding is chosen here, including disabled and buffer-off.
`ifndef IOPG_MAP_SVH
`define IOPG_MAP_SVH

`define IOPG_IDX_DIR        6'h00
`define IOPG_IDX_DIR_SET    6'h01
`define IOPG_IDX_DIR_CLR    6'h02
`define IOPG_IDX_DIR_TGL    6'h03
`define IOPG_IDX_OUT        6'h04
`define IOPG_IDX_OUT_SET    6'h05
`define IOPG_IDX_OUT_CLR    6'h06
`define IOPG_IDX_OUT_TGL    6'h07
`define IOPG_IDX_IN         6'h08
`define IOPG_IDX_FLAGS      6'h09
`define IOPG_IDX_CTRL       6'h0a
`define IOPG_IDX_PINCTRL    6'h10
`define IOPG_IDX_FAST_DIR   6'h20
`define IOPG_IDX_FAST_OUT   6'h21
`define IOPG_IDX_FAST_IN    6'h22
`define IOPG_IDX_FAST_FLAGS 6'h23

`define IOPG_PC_SENSE_LSB   0
`define IOPG_PC_SENSE_W     3
`define IOPG_PC_PULLUP_BIT  3
`define IOPG_PC_INVERT_BIT  7
`define IOPG_CTRL_SLEW_BIT  0

`define IOPG_RST_BYTE       8'h00
`define IOPG_DEAD_CYCLES    2'h3

`endif

// ==== hw/iopg_pkg.sv ====
/*
 Types of the I/O pin port group. Sense code values are set here, not in iopg_map.svh.
*/
package iopg_pkg;
   typedef enum logic [2:0] {
      SENSE_INTDISABLE = 3'h0,
      SENSE_BOTHEDGES  = 3'h1,
      SENSE_RISING     = 3'h2,
      SENSE_FALLING    = 3'h3,
      SENSE_BUFOFF     = 3'h4,
      SENSE_LEVEL      = 3'h5
   } iopg_sense_t;
endpackage

// ==== hw/iopg_port.sv ====
/*
 I/O pin port group: AHB-Lite register slave, pad control, input
 synchronisation, pin sensing, flags, interrupt, events and wake request.
 Assumes pad cells outside resolve padOut/padOe/weak_high_enable into the pin.
*/
`timescale 1ns/10ps
`include "iopg_map.svh"

module iopg_port #(
   parameter int PIN_COUNT = 8
) (
   input  wire logic                 clk_sys,
   input  wire logic                 rstn,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic [31:0]               hrdata,
   output logic                      hresp,
   input  wire logic [PIN_COUNT-1:0] padIn,
   output logic [PIN_COUNT-1:0]      padOut,
   output logic [PIN_COUNT-1:0]      padOe,
   output logic [PIN_COUNT-1:0]      weak_high_enable,
   output logic [PIN_COUNT-1:0]      inBufEn,
   output logic                      slewLimit,
   output logic [PIN_COUNT-1:0]      pinEvent,
   output logic                      irq,
   output logic                      wakeReq
);

   typedef struct packed {
      logic [PIN_COUNT-1:0]      dir;
      logic [PIN_COUNT-1:0]      out;
      logic [PIN_COUNT-1:0][7:0] pinCtrl;
      logic                      slew;
      logic [PIN_COUNT-1:0]      sync1;
      logic [PIN_COUNT-1:0]      sync2;
      logic [PIN_COUNT-1:0]      inVal;
      logic [PIN_COUNT-1:0]      flags;
      logic [PIN_COUNT-1:0][1:0] dead;
      logic                      wrPend;
      logic                      rdPend;
      logic [5:0]                idx;
      logic [31:0]               rdata;
   } iopg_state_t;

   iopg_state_t state_reg;
   iopg_state_t state_next;

   logic [PIN_COUNT-1:0] invert;
   logic [PIN_COUNT-1:0] bufOn;
   logic [PIN_COUNT-1:0] senseOn;
   logic [PIN_COUNT-1:0] rawVal;
   logic [PIN_COUNT-1:0] wakeBit;
   logic [PIN_COUNT-1:0] hit;
   logic [PIN_COUNT-1:0] newIn;
   logic [PIN_COUNT-1:0] wrBits;
   logic [PIN_COUNT-1:0] clrFlags;
   logic                 addrPhase;

   assign addrPhase = hsel && hready && htrans[1];
   assign wrBits    = hwdata[PIN_COUNT-1:0];

   genvar g;
   generate
      for (g = 0; g < PIN_COUNT; g++) begin : gPin
         iopg_pkg::iopg_sense_t sense;
         logic                  hitBit;
         assign sense      = iopg_pkg::iopg_sense_t'(
            state_reg.pinCtrl[g][`IOPG_PC_SENSE_LSB +: `IOPG_PC_SENSE_W]);
         assign invert[g]  = state_reg.pinCtrl[g][`IOPG_PC_INVERT_BIT];
         assign bufOn[g]   = (sense != iopg_pkg::SENSE_BUFOFF);
         // Unused codes must not enable wake or the request
         assign senseOn[g] = (sense == iopg_pkg::SENSE_BOTHEDGES)
                             || (sense == iopg_pkg::SENSE_RISING)
                             || (sense == iopg_pkg::SENSE_FALLING)
                             || (sense == iopg_pkg::SENSE_LEVEL);
         // Inversion after the synchroniser, so a polarity change is an edge
         assign newIn[g]   = bufOn[g] ? (state_reg.sync2[g] ^ invert[g])
                                      : state_reg.inVal[g]; // RULE_13 RULE_14 RULE_16
         always_comb begin
            case (sense)
               iopg_pkg::SENSE_BOTHEDGES: hitBit = newIn[g] != state_reg.inVal[g];
               iopg_pkg::SENSE_RISING:    hitBit = newIn[g] && !state_reg.inVal[g];
               iopg_pkg::SENSE_FALLING:   hitBit = !newIn[g] && state_reg.inVal[g];
               iopg_pkg::SENSE_LEVEL:     hitBit = !newIn[g];
               default:                   hitBit = 1'b0;
            endcase // RULE_17 RULE_24
         end
         assign hit[g] = hitBit;
         // Unclocked path: pin to event and wake, valid with the clock stopped
         assign rawVal[g]   = padIn[g] ^ invert[g];
         assign pinEvent[g] = bufOn[g] && rawVal[g]; // RULE_21
         assign wakeBit[g]  = senseOn[g] && ((sense == iopg_pkg::SENSE_LEVEL)
                              ? !rawVal[g] : (rawVal[g] != state_reg.inVal[g]));
         assign padOe[g]    = state_reg.dir[g]; // RULE_01 RULE_03
         assign padOut[g]   = state_reg.out[g] ^ invert[g]; // RULE_03 RULE_13
         assign weak_high_enable[g] = state_reg.pinCtrl[g][`IOPG_PC_PULLUP_BIT]
                              && !state_reg.dir[g]; // RULE_15
         assign inBufEn[g]  = bufOn[g]; // RULE_01
      end
   endgenerate

   assign wakeReq   = |wakeBit; // RULE_19
   assign irq       = |(state_reg.flags & senseOn); // RULE_20
   assign slewLimit = state_reg.slew; // RULE_11
   // Reads take one wait state so a preceding write is always visible
   assign hreadyout = !state_reg.rdPend;
   assign hrdata    = state_reg.rdata;
   assign hresp     = 1'b0;

   always_comb begin
      logic [31:0] rd;
      logic [5:0]  wi;
      rd         = 32'h0;
      wi         = state_reg.idx;
      state_next = state_reg;
      clrFlags   = '0;

      // Two flip-flop synchroniser
      state_next.sync1 = padIn; // RULE_04
      state_next.sync2 = state_reg.sync1; // RULE_04
      state_next.inVal = newIn; // RULE_04

      // Register write in its data phase, one low data bit per pin, or the low byte for a pin control register
      if (state_reg.wrPend) begin
         case (wi)
            `IOPG_IDX_DIR, `IOPG_IDX_FAST_DIR: state_next.dir = wrBits; // RULE_02 RULE_18
            `IOPG_IDX_DIR_SET: state_next.dir = state_reg.dir | wrBits; // RULE_05
            `IOPG_IDX_DIR_CLR: state_next.dir = state_reg.dir & ~wrBits; // RULE_06
            `IOPG_IDX_DIR_TGL: state_next.dir = state_reg.dir ^ wrBits; // RULE_07
            `IOPG_IDX_OUT, `IOPG_IDX_FAST_OUT: state_next.out = wrBits; // RULE_18
            `IOPG_IDX_OUT_SET: state_next.out = state_reg.out | wrBits; // RULE_08
            `IOPG_IDX_OUT_CLR: state_next.out = state_reg.out & ~wrBits; // RULE_09
            `IOPG_IDX_OUT_TGL, `IOPG_IDX_IN, `IOPG_IDX_FAST_IN:
               state_next.out = state_reg.out ^ wrBits; // RULE_10 RULE_18
            `IOPG_IDX_FLAGS, `IOPG_IDX_FAST_FLAGS: clrFlags = wrBits; // RULE_23 RULE_18
            `IOPG_IDX_CTRL: state_next.slew = hwdata[`IOPG_CTRL_SLEW_BIT]; // RULE_11
            default: begin
               if (wi >= `IOPG_IDX_PINCTRL
                   && wi < `IOPG_IDX_PINCTRL + 6'(PIN_COUNT)) begin
                  state_next.pinCtrl[3'(wi - `IOPG_IDX_PINCTRL)] = hwdata[7:0]; // RULE_12
               end
            end
         endcase
      end

      // Flags: a new hit wins over a clear in the same cycle
      for (int i = 0; i < PIN_COUNT; i++) begin
         if (state_reg.dead[i] != 2'h0) begin
            state_next.dead[i] = state_reg.dead[i] - 2'h1;
         end
         if (clrFlags[i]) begin
            state_next.flags[i] = 1'b0; // RULE_23
         end
         if (hit[i] && state_reg.dead[i] == 2'h0) begin
            state_next.flags[i] = 1'b1;
            state_next.dead[i]  = `IOPG_DEAD_CYCLES; // RULE_22
         end
      end

      // Read data captured in the wait state, after any write has landed
      if (state_reg.rdPend) begin
         case (wi)
            `IOPG_IDX_DIR, `IOPG_IDX_DIR_SET, `IOPG_IDX_DIR_CLR, `IOPG_IDX_DIR_TGL,
            `IOPG_IDX_FAST_DIR:
               rd[PIN_COUNT-1:0] = state_reg.dir;
            `IOPG_IDX_OUT, `IOPG_IDX_OUT_SET, `IOPG_IDX_OUT_CLR, `IOPG_IDX_OUT_TGL,
            `IOPG_IDX_FAST_OUT:
               rd[PIN_COUNT-1:0] = state_reg.out;
            `IOPG_IDX_IN, `IOPG_IDX_FAST_IN: rd[PIN_COUNT-1:0] = state_reg.inVal; // RULE_04
            `IOPG_IDX_FLAGS, `IOPG_IDX_FAST_FLAGS: rd[PIN_COUNT-1:0] = state_reg.flags;
            `IOPG_IDX_CTRL: rd[`IOPG_CTRL_SLEW_BIT] = state_reg.slew;
            default: begin
               if (wi >= `IOPG_IDX_PINCTRL
                   && wi < `IOPG_IDX_PINCTRL + 6'(PIN_COUNT)) begin
                  rd[7:0] = state_reg.pinCtrl[3'(wi - `IOPG_IDX_PINCTRL)]; // RULE_12
               end
            end
         endcase
         state_next.rdata = rd;
      end

      // Address phase; only whole-word single transfers are expected
      state_next.wrPend = 1'b0;
      state_next.rdPend = 1'b0;
      if (addrPhase && hreadyout) begin
         state_next.idx    = haddr[7:2];
         state_next.wrPend = hwrite;
         state_next.rdPend = !hwrite;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_reg <= '0; // RULE_01
      end else begin
         state_reg <= state_next;
      end
   end

endmodule

// ==== sim/iopg_checker.sv ====
/*
 Port checker for iopg_port, bound to every instance.
 Assumes hready is fed back from hreadyout by the single master.
*/
`timescale 1ns/10ps
module iopg_checker #(
   parameter int PIN_COUNT = 8
) (
   input wire logic                 clk_sys,
   input wire logic                 rstn,
   input wire logic                 hsel,
   input wire logic [1:0]           htrans,
   input wire logic                 hwrite,
   input wire logic                 hready,
   input wire logic                 hreadyout,
   input wire logic [PIN_COUNT-1:0] padOut,
   input wire logic [PIN_COUNT-1:0] padOe,
   input wire logic [PIN_COUNT-1:0] weak_high_enable,
   input wire logic [PIN_COUNT-1:0] inBufEn,
   input wire logic                 slewLimit,
   input wire logic [PIN_COUNT-1:0] pinEvent,
   input wire logic                 irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // Register outputs only move on the edge after a taken write, sampled two edges after it
   wire wrTaken = hsel && hready && htrans[1] && hwrite && hreadyout;
   wire rdTaken = hsel && hready && htrans[1] && !hwrite && hreadyout;
   chk_reset_state: assert property ($rose(rstn) |-> padOe == '0 && &inBufEn)
      else $error("pads not idle after reset");
   chk_pull_output: assert property ((weak_high_enable & padOe) == '0)
      else $error("pull-up on while driving");
   chk_event_buf: assert property ((pinEvent & ~inBufEn) == '0)
      else $error("event with buffer off");
   chk_irq_hold: assert property ($fell(irq) |-> $past(wrTaken, 2))
      else $error("irq dropped without write");
   chk_slew_cause: assert property ($changed(slewLimit) |-> $past(wrTaken, 2))
      else $error("slew changed without write");
   chk_oe_cause: assert property ($changed(padOe) |-> $past(wrTaken, 2))
      else $error("driver enable changed without write");
   chk_out_cause: assert property ($changed(padOut) |-> $past(wrTaken, 2))
      else $error("drive level changed without write");
   chk_inbuf_cause: assert property ($changed(inBufEn) |-> $past(wrTaken, 2))
      else $error("buffer enable changed without write");
   chk_read_wait: assert property (rdTaken |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   cov_irq: cover property ($rose(irq));
   cov_read: cover property (rdTaken);
   cov_slew: cover property ($rose(slewLimit));
endmodule
bind iopg_port iopg_checker #(.PIN_COUNT(PIN_COUNT)) chk_i (.clk_sys, .rstn, .hsel, .htrans,
   .hwrite, .hready, .hreadyout, .padOut, .padOe, .weak_high_enable, .inBufEn, .slewLimit, .pinEvent,
   .irq);

// ==== sim/iopg_pad_model.sv ====
/*
 Pad ring model: resolves drivers, pull-ups and external sources into pins.
 Assumes the bench drives extDrv/extEn just after clock edges.
*/
`timescale 1ns/10ps
module iopg_pad_model (
   input wire logic       clk_sys,
   input wire logic [7:0] padOut,
   input wire logic [7:0] padOe,
   input wire logic [7:0] weak_high_enable,
   input wire logic [7:0] extDrv,
   input wire logic       extEn,
   output logic     [7:0] padIn
);
   // Undriven pins wander so no settled value can pass for a drive
   logic [7:0] floatPat = 8'h55;
   always @(posedge clk_sys) floatPat <= ~floatPat;
   always_comb begin
      for (int n = 0; n < 8; n++) begin
         padIn[n] = padOe[n] ? padOut[n]
                  : extEn ? extDrv[n]
                  : weak_high_enable[n] ? 1'b1 : floatPat[n];
      end
   end
endmodule

// ==== sim/tb_top.sv ====
/*
 Self-checking bench for iopg_port over AHB-Lite with a pad model.
 Assumes iopg_checker is bound and the map header is on the include path.
*/
`timescale 1ns/10ps
`include "iopg_map.svh"
module tb_top;
   typedef struct packed {logic [5:0] idx; logic [7:0] wd, oe, out;} iopg_row_t;
   logic        clk_sys, rstn, hsel, hwrite, hreadyout, hresp, slewLimit, irq, wakeReq, extEn;
   logic        rdyN;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd, rdN;
   logic [7:0]  padIn, padOut, padOe, weak_high_enable, inBufEn, pinEvent, extDrv;
   int          num_errors, total_checks, cycles;
   iopg_row_t   rows [10] = '{'{`IOPG_IDX_DIR_SET, 8'h0f, 8'h0f, 8'h00},
      '{`IOPG_IDX_DIR_CLR, 8'h03, 8'h0c, 8'h00}, '{`IOPG_IDX_DIR_TGL, 8'h81, 8'h8d, 8'h00},
      '{`IOPG_IDX_OUT_SET, 8'hf0, 8'h8d, 8'hf0}, '{`IOPG_IDX_OUT_CLR, 8'h30, 8'h8d, 8'hc0},
      '{`IOPG_IDX_OUT_TGL, 8'h0f, 8'h8d, 8'hcf}, '{`IOPG_IDX_IN, 8'h81, 8'h8d, 8'h4e},
      '{`IOPG_IDX_FAST_DIR, 8'h55, 8'h55, 8'h4e}, '{`IOPG_IDX_FAST_OUT, 8'haa, 8'h55, 8'haa},
      '{`IOPG_IDX_DIR, 8'h00, 8'h00, 8'haa}};
   logic [7:0]  codes [4] = '{8'h01, 8'h02, 8'h03, 8'h05};
   logic [7:0]  fallExp [4] = '{8'h08, 8'h00, 8'h08, 8'h08};
   logic [7:0]  lowWake [4] = '{8'h00, 8'h00, 8'h00, 8'h01};

   iopg_port uut (.clk_sys, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hrdata, .hresp, .padIn, .padOut, .padOe, .weak_high_enable,
      .inBufEn, .slewLimit, .pinEvent, .irq, .wakeReq);
   iopg_pad_model pads (.clk_sys, .padOut, .padOe, .weak_high_enable, .extDrv, .extEn, .padIn);

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // Mid-cycle copies avoid racing the edge that updates them
   always @(negedge clk_sys) begin
      rdyN = hreadyout;
      rdN = hrdata;
   end
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         results();
      end
   end

   task automatic results();
      if (num_errors == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chkPin(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t pins %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic [5:0] idx, input logic wr, input logic [7:0] wd);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, idx, 2'h0};
      hwrite <= wr;
      do @(posedge clk_sys); while (rdyN !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h000000, wd};
      do @(posedge clk_sys); while (rdyN !== 1'b1);
      rd = rdN;
      #1;
   endtask
   task automatic settle();
      repeat (6) @(posedge clk_sys);
      #1;
   endtask

   initial begin
      {rstn, hsel, hwrite, htrans, haddr, hwdata, extEn, extDrv, cycles} = '0;
      {num_errors, total_checks} = '0;
      hsize = 3'h2;
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      #1;
      chkPin(padOe, 8'h00);
      chkPin(inBufEn, 8'hff);
      foreach (rows[i]) begin
         bus(rows[i].idx, 1'b1, rows[i].wd);
         chkPin(padOe, rows[i].oe);
         chkPin(padOut, rows[i].out);
      end
      bus(`IOPG_IDX_OUT, 1'b0, 8'h00);
      chkReg(rd, 32'h000000aa);
      bus(6'h0b, 1'b1, 8'hff);
      bus(6'h0b, 1'b0, 8'h00);
      chkReg(rd, 32'h00000000);
      chkPin({7'h00, hresp}, 8'h00);
      bus(`IOPG_IDX_CTRL, 1'b1, 8'h01);
      chkPin({7'h00, slewLimit}, 8'h01);
      bus(`IOPG_IDX_PINCTRL, 1'b1, 8'h08);
      chkPin(weak_high_enable, 8'h01);
      bus(`IOPG_IDX_DIR_SET, 1'b1, 8'h01);
      chkPin(weak_high_enable, 8'h00);
      bus(`IOPG_IDX_DIR_CLR, 1'b1, 8'h01);
      bus(`IOPG_IDX_PINCTRL + 6'h01, 1'b1, 8'h80);
      chkPin(padOut, 8'ha8);
      extEn <= 1'b1;
      extDrv <= 8'h3c;
      settle();
      bus(`IOPG_IDX_IN, 1'b0, 8'h00);
      chkReg(rd, 32'h0000003e);
      bus(`IOPG_IDX_FAST_IN, 1'b0, 8'h00);
      chkReg(rd, 32'h0000003e);
      bus(`IOPG_IDX_PINCTRL + 6'h02, 1'b1, 8'h04);
      chkPin(inBufEn, 8'hfb);
      extDrv <= 8'h38;
      settle();
      chkPin(pinEvent, 8'h3a);
      bus(`IOPG_IDX_IN, 1'b0, 8'h00);
      chkReg(rd, 32'h0000003e);
      // Pin 2 high again: its event must stay masked
      extDrv <= 8'h3c;
      settle();
      chkPin(pinEvent, 8'h3a);
      foreach (codes[i]) begin
         bus(`IOPG_IDX_PINCTRL + 6'h03, 1'b1, codes[i]);
         settle();
         bus(`IOPG_IDX_FLAGS, 1'b1, 8'hff);
         extDrv <= 8'h30;
         #1;
         chkPin({7'h00, wakeReq}, 8'h01);
         settle();
         chkPin({7'h00, wakeReq}, lowWake[i]);
         bus(`IOPG_IDX_FAST_FLAGS, 1'b0, 8'h00);
         chkReg(rd, {24'h000000, fallExp[i]});
         chkPin({7'h00, irq}, fallExp[i] >> 3);
         extDrv <= 8'h38;
         settle();
         bus(`IOPG_IDX_FLAGS, 1'b0, 8'h00);
         chkReg(rd, 32'h00000008);
         bus(`IOPG_IDX_FLAGS, 1'b1, 8'hff);
         chkPin({7'h00, irq}, 8'h00);
      end
      // Inverting a sensed pin is itself an edge
      bus(`IOPG_IDX_PINCTRL + 6'h03, 1'b1, 8'h01);
      bus(`IOPG_IDX_PINCTRL + 6'h03, 1'b1, 8'h81);
      settle();
      bus(`IOPG_IDX_FLAGS, 1'b0, 8'h00);
      chkReg(rd, 32'h00000008);
      // Mid-run reset with drivers on, slew set and a request pending
      bus(`IOPG_IDX_DIR_SET, 1'b1, 8'hff);
      rstn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      chkPin(padOe, 8'h00);
      chkPin(inBufEn, 8'hff);
      chkPin(padOut, 8'h00);
      chkPin({6'h00, slewLimit, irq}, 8'h00);
      @(posedge clk_sys);
      rstn <= 1'b1;
      settle();
      bus(`IOPG_IDX_DIR, 1'b0, 8'h00);
      chkReg(rd, 32'h00000000);
      results();
   end
endmodule
